// ---- design/tcsi_pkg.sv ----
// ****************************************************************
// constants and types of the channel status block
// ****************************************************************
package tcsi_pkg;

  // register byte offsets
  localparam logic [4:0] TCSI_OFS_VALUE_C   = 5'h00;
  localparam logic [4:0] TCSI_OFS_STATUS    = 5'h04;
  localparam logic [4:0] TCSI_OFS_IRQ_SET   = 5'h08;
  localparam logic [4:0] TCSI_OFS_IRQ_CLEAR = 5'h0C;
  localparam logic [4:0] TCSI_OFS_IRQ_MASK  = 5'h10;

  // status field positions
  localparam int TCSI_POS_EVENTS   = 0;
  localparam int TCSI_POS_CLK_RUN  = 16;
  localparam int TCSI_POS_MIRROR_A = 17;
  localparam int TCSI_POS_MIRROR_B = 18;

  // reset values
  localparam logic [7:0]  TCSI_RST_FLAGS   = 8'h00;
  localparam logic [7:0]  TCSI_RST_MASK    = 8'h00;
  localparam logic [15:0] TCSI_RST_VALUE_C = 16'h0000;

  // flags that exist only in capture mode / only in waveform mode
  localparam logic [7:0] TCSI_CAPTURE_ONLY  = 8'h62;
  localparam logic [7:0] TCSI_WAVEFORM_ONLY = 8'h0C;

  typedef enum logic {
    TCSI_MODE_CAPTURE  = 1'b0,
    TCSI_MODE_WAVEFORM = 1'b1
  } tcsi_mode_e;

  // event byte, bit 0 at the bottom
  typedef struct packed {
    logic ext_trigger_flag;
    logic load_b_flag;
    logic load_a_flag;
    logic match_c_flag;
    logic match_b_flag;
    logic match_a_flag;
    logic load_overrun_flag;
    logic overflow_flag;
  } tcsi_events_s;

  // strobes from the counter, capture and waveform engines
  typedef struct packed {
    logic overflow;
    logic match_a;
    logic match_b;
    logic match_c;
    logic load_a;
    logic load_b;
    logic ext_trigger;
    logic value_a_read;
    logic value_b_read;
  } tcsi_strobes_s;

endpackage : tcsi_pkg

// ---- design/tcsi_top.sv ----
`timescale 1ns/10ps
// Overview of operation
// R1 - event flags bits 0..7 in fixed order
// R2 - clock status bit 16, mirrors bits 17,18
// R3 - overflow flag sticky until status read
// R4 - capture mode double load sets overrun
// R5 - waveform compare A/B flags, else zero
// R6 - compare C flag in either mode
// R7 - capture load A/B flags, else zero
// R8 - external trigger flag sticky until read
// R9 - clock running bit is live level
// R10 - line A mirror: pin or driven level
// R11 - line B mirror: pin or driven level
// R12 - enable-set write sets mask bits
// R13 - enable-clear write clears mask bits
// R14 - mask register reads enabled sources
// R15 - value C reads current contents
// R16 - mode bit zero capture, one waveform
// R17 - irq while enabled flag set
// R18 - event during status read kept
module tcsi_top
  import tcsi_pkg::*;
#(
  parameter int VALUE_W = 16
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // avalon-mm slave
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // engine side
  input  wire tcsi_strobes_s      engine_strobes,
  input  wire logic               waveform_mode,
  input  wire logic               clock_enabled,
  input  wire logic               line_a_drive,
  input  wire logic               line_b_drive,
  output logic      [VALUE_W-1:0] value_c_reg,
  // pins
  input  wire logic               io_line_a,
  input  wire logic               io_line_b,
  // interrupt
  output logic                    channel_irq
);

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  logic         ack_reg;
  logic         req;
  logic         acc_rd;
  logic         acc_wr;
  logic [4:0]   word_ofs;
  logic [7:0]   reported_reg;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign acc_rd          = avs_read & ack_reg;
  assign acc_wr          = avs_write & ack_reg;
  assign word_ofs        = {avs_address[4:2], 2'b00};

  // one wait state per access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 2'b00;
      pin_sync_reg <= 2'b00;
    end else begin
      pin_meta_reg <= {io_line_b, io_line_a};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************************
  // mode and live status
  // ****************************************************************
  tcsi_mode_e mode;
  logic [7:0] mode_allow;
  logic       mirror_a;
  logic       mirror_b;

  assign mode       = tcsi_mode_e'(waveform_mode);                              // R16
  assign mode_allow = (mode == TCSI_MODE_WAVEFORM) ? ~TCSI_CAPTURE_ONLY
                                                   : ~TCSI_WAVEFORM_ONLY;       // R5 R7 R4
  assign mirror_a   = (mode == TCSI_MODE_WAVEFORM) ? line_a_drive : pin_sync_reg[0]; // R10
  assign mirror_b   = (mode == TCSI_MODE_WAVEFORM) ? line_b_drive : pin_sync_reg[1]; // R11

  // ****************************************************************
  // load overrun tracking
  // ****************************************************************
  logic pend_a_reg;
  logic pend_b_reg;
  logic overrun;

  assign overrun = (engine_strobes.load_a & pend_a_reg & ~engine_strobes.value_a_read)
                 | (engine_strobes.load_b & pend_b_reg & ~engine_strobes.value_b_read); // R4

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else begin
      pend_a_reg <= engine_strobes.load_a | (pend_a_reg & ~engine_strobes.value_a_read);
      pend_b_reg <= engine_strobes.load_b | (pend_b_reg & ~engine_strobes.value_b_read);
    end
  end

  // ****************************************************************
  // sticky event flags
  // ****************************************************************
  tcsi_events_s set_evt;
  logic [7:0]   flags_reg;
  logic [7:0]   flags_next;
  logic [7:0]   flags_vis;
  logic [7:0]   clr_bits;

  always_comb begin
    set_evt                   = '0;
    set_evt.overflow_flag     = engine_strobes.overflow;    // R3
    set_evt.load_overrun_flag = overrun;                    // R4
    set_evt.match_a_flag      = engine_strobes.match_a;     // R5
    set_evt.match_b_flag      = engine_strobes.match_b;     // R5
    set_evt.match_c_flag      = engine_strobes.match_c;     // R6
    set_evt.load_a_flag       = engine_strobes.load_a;      // R7
    set_evt.load_b_flag       = engine_strobes.load_b;      // R7
    set_evt.ext_trigger_flag  = engine_strobes.ext_trigger; // R8
  end

  // read clears only the bits it reported; write one also clears
  always_comb begin
    clr_bits = 8'h00;
    if (acc_rd && word_ofs == TCSI_OFS_STATUS) begin
      clr_bits = reported_reg;                              // R3 R8
    end else if (acc_wr && word_ofs == TCSI_OFS_STATUS && avs_byteenable[0]) begin
      clr_bits = avs_writedata[7:0];
    end
  end

  assign flags_next = (flags_reg & ~clr_bits) | (set_evt & mode_allow); // R18
  assign flags_vis  = flags_reg & mode_allow;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= TCSI_RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ****************************************************************
  // interrupt mask
  // ****************************************************************
  logic [7:0] mask_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= TCSI_RST_MASK;
    end else if (acc_wr && avs_byteenable[0]) begin
      if (word_ofs == TCSI_OFS_IRQ_SET) begin
        mask_reg <= mask_reg | avs_writedata[7:0];          // R12
      end else if (word_ofs == TCSI_OFS_IRQ_CLEAR) begin
        mask_reg <= mask_reg & ~avs_writedata[7:0];         // R13
      end
    end
  end

  assign channel_irq = |(flags_vis & mask_reg);             // R17

  // ****************************************************************
  // compare value c
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_c_reg <= VALUE_W'(TCSI_RST_VALUE_C);
    end else if (acc_wr && word_ofs == TCSI_OFS_VALUE_C) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b] && b * 8 < VALUE_W) begin
          for (int i = 0; i < 8; i++) begin
            if (b * 8 + i < VALUE_W) begin
              value_c_reg[b*8+i] <= avs_writedata[b*8+i];
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (word_ofs)
      TCSI_OFS_VALUE_C: begin
        rd_mux[VALUE_W-1:0] = value_c_reg;                  // R15
      end
      TCSI_OFS_STATUS: begin
        rd_mux[TCSI_POS_EVENTS +: 8]  = flags_vis;          // R1
        rd_mux[TCSI_POS_CLK_RUN]      = clock_enabled;      // R2 R9
        rd_mux[TCSI_POS_MIRROR_A]     = mirror_a;           // R2
        rd_mux[TCSI_POS_MIRROR_B]     = mirror_b;           // R2
      end
      TCSI_OFS_IRQ_MASK: begin
        rd_mux[7:0] = mask_reg;                             // R14
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
      reported_reg <= 8'h00;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_mux;
      reported_reg <= (word_ofs == TCSI_OFS_STATUS) ? flags_vis : 8'h00;
    end
  end

endmodule : tcsi_top

// ---- dv/tcsi_top_chk.sv ----
`timescale 1ns/10ps
// ************************
// status and irq checker
// ************************
module tcsi_top_chk
  import tcsi_pkg::*;
(
  // clock, reset, bus
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic [4:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  // engine side and interrupt
  input wire tcsi_strobes_s engine_strobes,
  input wire logic          waveform_mode,
  input wire logic          clock_enabled,
  input wire logic          line_a_drive,
  input wire logic          line_b_drive,
  input wire logic          channel_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire st_rd = avs_read && !avs_waitrequest && avs_address[4:2] == TCSI_OFS_STATUS[4:2];
  wire mk_rd = avs_read && !avs_waitrequest && avs_address[4:2] == TCSI_OFS_IRQ_MASK[4:2];
  wire cause = |engine_strobes[8:2] | avs_write;
  property p_resv; st_rd |-> avs_readdata[31:19] == 13'h0000 && avs_readdata[15:8] == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_clk; st_rd |-> avs_readdata[16] == $past(clock_enabled); endproperty
  a_clk: assert property (p_clk) else $error("clock status wrong");
  property p_mir_a; st_rd && $past(waveform_mode) |-> avs_readdata[17] == $past(line_a_drive); endproperty
  a_mir_a: assert property (p_mir_a) else $error("line a mirror wrong");
  property p_mir_b; st_rd && $past(waveform_mode) |-> avs_readdata[18] == $past(line_b_drive); endproperty
  a_mir_b: assert property (p_mir_b) else $error("line b mirror wrong");
  property p_cap; st_rd && !$past(waveform_mode) |-> (avs_readdata[7:0] & TCSI_WAVEFORM_ONLY) == 8'h00; endproperty
  a_cap: assert property (p_cap) else $error("compare flag in capture");
  property p_wav; st_rd && $past(waveform_mode) |-> (avs_readdata[7:0] & TCSI_CAPTURE_ONLY) == 8'h00; endproperty
  a_wav: assert property (p_wav) else $error("load flag in waveform");
  property p_mask; mk_rd |-> avs_readdata[31:8] == 24'h000000; endproperty
  a_mask: assert property (p_mask) else $error("mask upper bits set");
  property p_irq; $rose(channel_irq) && $stable(waveform_mode) |-> $past(cause); endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
endmodule // tcsi_top_chk

bind tcsi_top tcsi_top_chk u_chk (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .engine_strobes, .waveform_mode, .clock_enabled, .line_a_drive, .line_b_drive, .channel_irq);

// ---- dv/tcsi_top_test.sv ----
`timescale 1ns/10ps
module tcsi_top_test;
  import tcsi_pkg::*;
  logic          ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, channel_irq;
  logic          waveform_mode, clock_enabled, line_a_drive, line_b_drive, io_line_a, io_line_b;
  logic [4:0]    avs_address;
  logic [3:0]    avs_byteenable;
  logic [31:0]   avs_writedata, avs_readdata, d;
  logic [15:0]   value_c_reg;
  tcsi_strobes_s engine_strobes;
  int            n_errors, compares, cyc;
  tcsi_top dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .engine_strobes, .waveform_mode, .clock_enabled, .line_a_drive,
    .line_b_drive, .value_c_reg, .io_line_a, .io_line_b, .channel_irq);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end
  task results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus access, strobes s driven in its first cycle
  task xf(input logic w, input logic [4:0] a, input logic [31:0] wd, input logic [8:0] s);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= wd;
    engine_strobes <= s;
    @(posedge ref_clk);
    engine_strobes <= '0;
    // look mid-cycle, then take the answer at the edge that samples it low
    @(negedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(negedge ref_clk);
    @(posedge ref_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rs(input logic [4:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0, 9'h000);
    chk(d, e);
  endtask
  task pl(input logic [8:0] s);
    @(posedge ref_clk);
    engine_strobes <= s;
    @(posedge ref_clk);
    engine_strobes <= '0;
  endtask
  task t_reset;
    rs(TCSI_OFS_IRQ_MASK, 32'h0);
    rs(TCSI_OFS_STATUS, 32'h0);
    rs(TCSI_OFS_VALUE_C, 32'h0);
    rs(5'h14, 32'h0);
  endtask
  task t_cap;
    clock_enabled <= 1'b1;
    io_line_a <= 1'b1;
    for (int i = 8; i >= 2; i--) pl(9'h001 << i);
    rs(TCSI_OFS_STATUS, 32'h0003_00F1);
    rs(TCSI_OFS_STATUS, 32'h0003_0000);
  endtask
  task t_wav;
    waveform_mode <= 1'b1;
    line_b_drive <= 1'b1;
    for (int i = 8; i >= 2; i--) pl(9'h001 << i);
    rs(TCSI_OFS_STATUS, 32'h0005_009D);
  endtask
  task t_ovr;
    waveform_mode <= 1'b0;
    pl(9'h003);
    pl(9'h010);
    pl(9'h010);
    pl(9'h008);
    pl(9'h001);
    pl(9'h008);
    rs(TCSI_OFS_STATUS, 32'h0003_0062);
  endtask
  task t_irq;
    xf(1'b1, TCSI_OFS_IRQ_SET, 32'h81, 9'h000);
    rs(TCSI_OFS_IRQ_MASK, 32'h81);
    xf(1'b1, TCSI_OFS_IRQ_CLEAR, 32'h01, 9'h000);
    rs(TCSI_OFS_IRQ_MASK, 32'h80);
    pl(9'h100);
    @(posedge ref_clk);
    chk({31'h0, channel_irq}, 32'h0);
    pl(9'h004);
    @(posedge ref_clk);
    chk({31'h0, channel_irq}, 32'h1);
    rs(TCSI_OFS_STATUS, 32'h0003_0081);
    @(posedge ref_clk);
    chk({31'h0, channel_irq}, 32'h0);
    xf(1'b1, TCSI_OFS_VALUE_C, 32'h0000_A5C3, 9'h000);
    @(negedge ref_clk);
    chk({16'h0000, value_c_reg}, 32'h0000_A5C3);
    rs(TCSI_OFS_VALUE_C, 32'h0000_A5C3);
  endtask
  task t_same;
    xf(1'b0, TCSI_OFS_STATUS, 32'h0, 9'h004);
    chk(d, 32'h0003_0000);
    rs(TCSI_OFS_STATUS, 32'h0003_0080);
  endtask
  initial begin
    {rst_n, avs_read, avs_write, waveform_mode, clock_enabled, line_a_drive, line_b_drive} = '0;
    {io_line_a, io_line_b, avs_address, avs_writedata, engine_strobes} = '0;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_cap();
    t_wav();
    t_ovr();
    t_irq();
    t_same();
    results();
  end
endmodule // tcsi_top_test
